// File: sez_pkg.sv
package sez_pkg;

    // Commands as seen by the access-policy logic after command parsing.
    typedef enum logic [3:0] {
        CMD_READ              = 4'h0,
        CMD_WRITE             = 4'h1,
        CMD_LOCK_SLOT         = 4'h2,
        CMD_VERIFY_STORED     = 4'h3,
        CMD_VERIFY_VALIDATE   = 4'h4,
        CMD_VERIFY_INVALIDATE = 4'h5,
        CMD_MAC               = 4'h6,
        CMD_DIGEST_GENERATE   = 4'h7,
        CMD_HASH_INIT         = 4'h8,
        CMD_HASH_UPDATE       = 4'h9,
        CMD_HASH_FINAL        = 4'hA,
        CMD_NONCE             = 4'hB,
        CMD_KEY_DERIVATION    = 4'hC,
        CMD_SIGN              = 4'hD
    } sez_cmd_type;

    typedef enum logic [1:0] {
        ZONE_DATA = 2'h0,
        ZONE_OTP  = 2'h1,
        ZONE_SRAM = 2'h2
    } sez_zone_type;

    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_BURST = 1'b1
    } sez_fsm_type;

    localparam logic [3:0] SLOT_PARENT    = 4'hD;
    localparam logic [3:0] SLOT_VALIDATED = 4'hE;
    localparam logic [3:0] SLOT_BOOT      = 4'hF;

    localparam logic [7:0] STAT_OK         = 8'h00;
    localparam logic [7:0] STAT_MISCOMPARE = 8'h01;
    localparam logic [7:0] STAT_REFUSED    = 8'h0F;

    localparam int         OTP_BYTES    = 64;
    localparam int         BLOCK_BYTES  = 32;
    localparam int         WORD_BYTES   = 4;
    localparam logic [2:0] BEAT_LAST    = 3'h7;
    localparam logic [2:0] BEAT_FIRST   = 3'h0;
    localparam logic [2:0] BEAT_SECOND  = 3'h1;

    typedef struct packed {
        logic         valid;      // One-cycle request strobe.
        sez_cmd_type  cmd;        // Command after parsing.
        sez_zone_type zone;       // Addressed zone.
        logic [3:0]   slot;       // Data slot number.
        logic         long_read;  // Set for a 32-byte read.
        logic [3:0]   word;       // OTP word index; bit 3 picks the block.
        logic         engine_ok;  // Crypto engine reports a match.
    } sez_req_type;

    typedef struct packed {
        logic        valid;    // One-cycle answer strobe.
        logic        granted;  // Command may proceed.
        logic [7:0]  status;   // Status code for the answer.
        logic [31:0] data;     // OTP read data, zero otherwise.
        logic        last;     // Final word of the answer.
    } sez_resp_type;

    typedef struct packed {
        logic scratch_hi;  // Upper half of scratch key holds data.
        logic scratch_lo;  // Lower half of scratch key holds data.
        logic digest;      // Message digest buffer holds data.
        logic alt_key;     // Alternate key buffer holds data.
        logic alt_secret;  // Alternate key came from key derivation.
        logic hash_ctx;    // Hash context is in progress.
    } sez_sram_type;

endpackage : sez_pkg

// File: sez_slot_policy.sv
`timescale 1ns/1ps
module sez_slot_policy (
    input  sez_pkg::sez_cmd_type  cmd_i,        // Requested command.
    input  wire logic [3:0]       slot_i,       // Addressed slot.
    input  wire logic             perm13_i,     // Slot 13 permanently locked.
    input  wire logic             perm15_i,     // Slot 15 permanently locked.
    input  wire logic             locked13_i,   // Slot 13 lock state.
    input  wire logic             locked15_i,   // Slot 15 lock state.
    input  wire logic             key_valid_i,  // Slot 14 key validated.
    output logic                  allowed_o     // Command permitted.
);

    always_comb begin
        allowed_o = 1'b0;
        if (slot_i == sez_pkg::SLOT_PARENT) begin
            case (cmd_i)
                sez_pkg::CMD_WRITE:
                    allowed_o = !perm13_i && !locked13_i;
                sez_pkg::CMD_READ,
                sez_pkg::CMD_LOCK_SLOT,
                sez_pkg::CMD_VERIFY_STORED,
                sez_pkg::CMD_MAC,
                sez_pkg::CMD_DIGEST_GENERATE:
                    allowed_o = 1'b1;
                default:
                    allowed_o = 1'b0;
            endcase
        end else if (slot_i == sez_pkg::SLOT_VALIDATED) begin
            case (cmd_i)
                sez_pkg::CMD_WRITE:
                    allowed_o = !key_valid_i;
                sez_pkg::CMD_READ:
                    allowed_o = 1'b1;
                sez_pkg::CMD_VERIFY_STORED:
                    allowed_o = key_valid_i;
                sez_pkg::CMD_VERIFY_VALIDATE,
                sez_pkg::CMD_VERIFY_INVALIDATE:
                    allowed_o = 1'b1;
                default:
                    allowed_o = 1'b0;
            endcase
        end else if (slot_i == sez_pkg::SLOT_BOOT) begin
            case (cmd_i)
                sez_pkg::CMD_WRITE:
                    allowed_o = !perm15_i && !locked15_i;
                sez_pkg::CMD_READ,
                sez_pkg::CMD_LOCK_SLOT,
                sez_pkg::CMD_MAC,
                sez_pkg::CMD_DIGEST_GENERATE:
                    allowed_o = 1'b1;
                default:
                    allowed_o = 1'b0;
            endcase
        end
    end

endmodule : sez_slot_policy

// File: sez_zone_access.sv
`timescale 1ns/1ps
// Summary of operation
// - The OTP zone holds 64 bytes as two 32-byte blocks.
// - The OTP zone ships locked; every write to it is refused.
// - OTP reads of 4 or 32 bytes answer unless a burst is running; bytes never change.
// - SRAM buffer contents are never returned to the host.
// - Sleep or power loss marks all SRAM contents invalid.
// - A 64-byte scratch key with two halves is usable only internally.
// - A 64-byte digest buffer feeds verify and sign.
// - Hash finalize writes its digest straight into the digest buffer.
// - A 32-byte alternate key is loaded by nonce or key derivation.
// - Hash context persists across init, update and finalize phases.
// - Lockable slot 13 takes writes until locked; reads always allowed.
// - Permanently locked slot 13 or 15 refuses writes, keeps the rest.
// - Slot 14 writes need its key invalidated first by the host.
// - Stored-mode verify uses the slot 14 key only while validated.
// - Slot 14 is always readable in the clear.
// - Lockable slot 15 takes writes until locked; limited command set.
module sez_zone_access #(
    parameter int           OTP_BYTES   = 64,  // OTP zone size.
    parameter int           BLOCK_BYTES = 32,  // OTP block size.
    // Image of the OTP zone; the default value is arbitrary.
    parameter logic [511:0] OTP_IMAGE   = {8'hA5, 8'h5A, 8'h3C, 8'hC3, 480'h0},
    parameter logic         KEY_VALID_RESET = 1'b0  // Slot 14 key at start.
) (
    input  wire logic                  clk_i,          // 50 MHz clock.
    input  wire logic                  rst_b_i,        // Power-on reset.
    input  sez_pkg::sez_req_type       req_i,          // Command request.
    input  wire logic                  sleep_i,        // Device enters sleep.
    input  wire logic                  slot13_perm_i,  // Slot 13 option 2.
    input  wire logic                  slot15_perm_i,  // Slot 15 option 2.
    output sez_pkg::sez_resp_type      resp_o,         // Answer.
    output logic                       busy_o,         // Burst in progress.
    output logic                       locked13_o,     // Slot 13 locked.
    output logic                       locked15_o,     // Slot 15 locked.
    output logic                       key_valid_o,    // Slot 14 validated.
    output sez_pkg::sez_sram_type      sram_valid_o    // SRAM buffer tags.
);

    localparam int OTP_WORDS = OTP_BYTES / sez_pkg::WORD_BYTES;

    generate
        if (OTP_BYTES != sez_pkg::OTP_BYTES ||
            BLOCK_BYTES != sez_pkg::BLOCK_BYTES) begin : g_bad_size
            $error("OTP geometry must be two blocks of eight words");
        end
    endgenerate

    typedef struct packed {
        sez_pkg::sez_fsm_type  fsm;
        logic                  blk;
        logic [2:0]            beat;
        logic                  locked13;
        logic                  locked15;
        logic                  key_valid;
        sez_pkg::sez_sram_type sram;
        sez_pkg::sez_resp_type resp;
    } sez_state_type;

    sez_state_type st;
    sez_state_type next_st;
    logic          allowed;

    // Read-only image of the OTP zone, one entry per 32-bit word.
    logic [31:0] otp_mem [OTP_WORDS];

    always_comb begin
        for (int i = 0; i < OTP_WORDS; i++) begin
            otp_mem[i] = OTP_IMAGE[511 - 32 * i -: 32];
        end
    end

    function automatic sez_pkg::sez_resp_type answer(
        input logic        granted,
        input logic [7:0]  status,
        input logic [31:0] data,
        input logic        last
    );
        sez_pkg::sez_resp_type r;
        r.valid   = 1'b1;
        r.granted = granted;
        r.status  = status;
        r.data    = data;
        r.last    = last;
        return r;
    endfunction : answer

    // Plain verdict with no data: grant with OK status or refuse.
    function automatic sez_pkg::sez_resp_type verdict(input logic ok);
        return answer(ok, ok ? sez_pkg::STAT_OK : sez_pkg::STAT_REFUSED,
                      32'h0, 1'b1);
    endfunction : verdict

    function automatic logic [31:0] otp_word(
        input logic       blk,
        input logic [2:0] beat
    );
        otp_word = otp_mem[{blk, beat}];
    endfunction : otp_word

    sez_slot_policy u_policy (
        .cmd_i       (req_i.cmd),
        .slot_i      (req_i.slot),
        .perm13_i    (slot13_perm_i),
        .perm15_i    (slot15_perm_i),
        .locked13_i  (st.locked13),
        .locked15_i  (st.locked15),
        .key_valid_i (st.key_valid),
        .allowed_o   (allowed)
    );

    always_comb begin
        next_st       = st;
        next_st.resp  = '0;
        case (st.fsm)
            sez_pkg::ST_BURST: begin
                // A 32-byte OTP read streams one word per cycle.
                next_st.resp = answer(1'b1, sez_pkg::STAT_OK,
                                      otp_word(st.blk, st.beat),
                                      st.beat == sez_pkg::BEAT_LAST);
                if (st.beat == sez_pkg::BEAT_LAST) begin
                    next_st.fsm  = sez_pkg::ST_IDLE;
                    next_st.beat = sez_pkg::BEAT_FIRST;
                end else begin
                    next_st.beat = st.beat + 3'h1;
                end
            end
            default: begin
                if (req_i.valid && req_i.zone == sez_pkg::ZONE_OTP) begin
                    if (req_i.cmd == sez_pkg::CMD_READ && req_i.long_read) begin
                        next_st.resp = answer(1'b1, sez_pkg::STAT_OK,
                                              otp_word(req_i.word[3],
                                                       sez_pkg::BEAT_FIRST),
                                              1'b0);
                        next_st.fsm  = sez_pkg::ST_BURST;
                        next_st.blk  = req_i.word[3];
                        next_st.beat = sez_pkg::BEAT_SECOND;
                    end else if (req_i.cmd == sez_pkg::CMD_READ) begin
                        next_st.resp = answer(1'b1, sez_pkg::STAT_OK,
                                              otp_mem[req_i.word],
                                              1'b1);
                    end else begin
                        next_st.resp = verdict(1'b0);
                    end
                end else if (req_i.valid &&
                             req_i.zone == sez_pkg::ZONE_SRAM) begin
                    next_st.resp = verdict(1'b0);
                end else if (req_i.valid) begin
                    case (req_i.cmd)
                        sez_pkg::CMD_HASH_INIT: begin
                            next_st.sram.hash_ctx = 1'b1;
                            next_st.resp = verdict(1'b1);
                        end
                        sez_pkg::CMD_HASH_UPDATE: begin
                            next_st.resp = verdict(st.sram.hash_ctx);
                        end
                        sez_pkg::CMD_HASH_FINAL: begin
                            if (st.sram.hash_ctx) begin
                                next_st.sram.hash_ctx = 1'b0;
                                next_st.sram.digest   = 1'b1;
                            end
                            next_st.resp = verdict(st.sram.hash_ctx);
                        end
                        sez_pkg::CMD_NONCE: begin
                            next_st.sram.alt_key    = 1'b1;
                            next_st.sram.alt_secret = 1'b0;
                            next_st.resp = verdict(1'b1);
                        end
                        sez_pkg::CMD_KEY_DERIVATION: begin
                            next_st.sram.alt_key    = 1'b1;
                            next_st.sram.alt_secret = 1'b1;
                            next_st.resp = verdict(1'b1);
                        end
                        sez_pkg::CMD_SIGN: begin
                            next_st.resp = verdict(st.sram.digest);
                        end
                        default: begin
                            if (!allowed) begin
                                next_st.resp = verdict(1'b0);
                            end else if (req_i.cmd ==
                                         sez_pkg::CMD_VERIFY_STORED &&
                                         !st.sram.digest) begin
                                // Verify needs a digest to check against.
                                next_st.resp = verdict(1'b0);
                            end else if (req_i.cmd ==
                                         sez_pkg::CMD_VERIFY_VALIDATE &&
                                         !req_i.engine_ok) begin
                                next_st.resp = answer(1'b0,
                                                      sez_pkg::STAT_MISCOMPARE,
                                                      32'h0, 1'b1);
                            end else begin
                                next_st.resp = verdict(1'b1);
                                if (req_i.cmd == sez_pkg::CMD_VERIFY_VALIDATE)
                                begin
                                    next_st.key_valid = 1'b1;
                                end
                                if (req_i.cmd ==
                                    sez_pkg::CMD_VERIFY_INVALIDATE) begin
                                    next_st.key_valid = 1'b0;
                                end
                                if (req_i.cmd == sez_pkg::CMD_DIGEST_GENERATE)
                                begin
                                    next_st.sram.scratch_hi = 1'b1;
                                    next_st.sram.scratch_lo = 1'b1;
                                end
                                if (req_i.cmd == sez_pkg::CMD_LOCK_SLOT &&
                                    req_i.slot == sez_pkg::SLOT_PARENT) begin
                                    next_st.locked13 = 1'b1;
                                end
                                if (req_i.cmd == sez_pkg::CMD_LOCK_SLOT &&
                                    req_i.slot == sez_pkg::SLOT_BOOT) begin
                                    next_st.locked15 = 1'b1;
                                end
                            end
                        end
                    endcase
                end
            end
        endcase
        // Sleep wipes every SRAM buffer, even one loaded this cycle.
        if (sleep_i) begin
            next_st.sram = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st           <= '0;
            st.key_valid <= KEY_VALID_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign resp_o       = st.resp;
    assign busy_o       = st.fsm == sez_pkg::ST_BURST;
    assign locked13_o   = st.locked13 | slot13_perm_i;
    assign locked15_o   = st.locked15 | slot15_perm_i;
    assign key_valid_o  = st.key_valid;
    assign sram_valid_o = st.sram;

endmodule : sez_zone_access

// File: sez_zone_access_monitor.sv
`timescale 1ns/1ps
module sez_zone_access_monitor #(
    parameter logic [511:0] OTP_IMAGE = 512'h0  // Zone image.
) (
    input  wire logic             clk_i,          // Clock.
    input  wire logic             rst_b_i,        // Reset, active low.
    input  sez_pkg::sez_req_type  req_i,          // Request.
    input  wire logic             sleep_i,        // Sleep.
    input  wire logic             slot13_perm_i,  // Slot 13 option.
    input  wire logic             slot15_perm_i,  // Slot 15 option.
    input  sez_pkg::sez_resp_type resp_o,         // Answer.
    input  wire logic             busy_o,         // Burst running.
    input  wire logic             locked13_o,     // Slot 13 lock.
    input  wire logic             locked15_o,     // Slot 15 lock.
    input  wire logic             key_valid_o,    // Slot 14 key.
    input  sez_pkg::sez_sram_type sram_valid_o    // SRAM tags.
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic tk  = req_i.valid && !busy_o;
    wire logic otp = tk && req_i.zone == sez_pkg::ZONE_OTP;
    wire logic dat = tk && req_i.zone == sez_pkg::ZONE_DATA;
    wire logic rd  = req_i.cmd == sez_pkg::CMD_READ;
    wire logic wr  = req_i.cmd == sez_pkg::CMD_WRITE;
    sequence s_refused;
        resp_o.valid && !resp_o.granted
            && resp_o.status == sez_pkg::STAT_REFUSED;
    endsequence
    sequence s_mid_word;
        resp_o.valid && !resp_o.last;
    endsequence
    property p_otp_write;
        otp && !rd |=> s_refused;
    endproperty
    property p_sram_hidden;
        tk && req_i.zone == sez_pkg::ZONE_SRAM
            |=> s_refused ##0 resp_o.data == 32'h0;
    endproperty
    property p_sleep;
        sleep_i |=> sram_valid_o == '0;
    endproperty
    property p_burst;
        otp && rd && req_i.long_read
            |=> s_mid_word [*7] ##1 (resp_o.valid && resp_o.last);
    endproperty
    property p_short;
        otp && rd && !req_i.long_read |=> resp_o.last
            && resp_o.data == OTP_IMAGE[511-32*$past(req_i.word) -: 32];
    endproperty
    property p_lock13;
        dat && wr && req_i.slot == sez_pkg::SLOT_PARENT && locked13_o
            |=> s_refused;
    endproperty
    property p_slot15;
        dat && req_i.slot == sez_pkg::SLOT_BOOT && req_i.cmd inside
            {sez_pkg::CMD_VERIFY_STORED, sez_pkg::CMD_VERIFY_VALIDATE}
            |=> s_refused;
    endproperty
    property p_key14;
        dat && wr && req_i.slot == sez_pkg::SLOT_VALIDATED && key_valid_o
            |=> s_refused;
    endproperty
    property p_stored;
        dat && req_i.cmd == sez_pkg::CMD_VERIFY_STORED && !key_valid_o
            && req_i.slot == sez_pkg::SLOT_VALIDATED |=> s_refused;
    endproperty
    property p_read;
        dat && rd && req_i.slot >= sez_pkg::SLOT_PARENT
            |=> resp_o.granted && resp_o.status == sez_pkg::STAT_OK;
    endproperty
    property p_hash;
        dat && req_i.cmd == sez_pkg::CMD_HASH_FINAL && !sleep_i
            && sram_valid_o.hash_ctx
            |=> sram_valid_o.digest && !sram_valid_o.hash_ctx;
    endproperty
    a_otp_write: assert property (p_otp_write)
        else $error("OTP write was not refused");
    a_sram_hidden: assert property (p_sram_hidden)
        else $error("SRAM access was not refused");
    a_sleep: assert property (p_sleep)
        else $error("Sleep left SRAM tags set");
    a_burst: assert property (p_burst)
        else $error("Long OTP read not eight words");
    a_short: assert property (p_short)
        else $error("Short OTP read data wrong");
    a_lock13: assert property (p_lock13)
        else $error("Locked slot 13 took a write");
    a_slot15: assert property (p_slot15)
        else $error("Slot 15 took a verify");
    a_key14: assert property (p_key14)
        else $error("Slot 14 write with valid key");
    a_stored: assert property (p_stored)
        else $error("Stored verify with invalid key");
    a_read: assert property (p_read)
        else $error("Slot read was refused");
    a_hash: assert property (p_hash)
        else $error("Hash final did not fill digest");
endmodule : sez_zone_access_monitor

bind sez_zone_access sez_zone_access_monitor #(.OTP_IMAGE(OTP_IMAGE))
    sez_zone_access_monitor_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .req_i(req_i), .sleep_i(sleep_i), .slot13_perm_i(slot13_perm_i),
    .slot15_perm_i(slot15_perm_i), .resp_o(resp_o), .busy_o(busy_o),
    .locked13_o(locked13_o), .locked15_o(locked15_o),
    .key_valid_o(key_valid_o), .sram_valid_o(sram_valid_o));

// File: sez_host_model.sv
`timescale 1ns/1ps
module sez_host_model (
    input  wire logic            clk_i,  // Device clock.
    output sez_pkg::sez_req_type req_o   // Request to the block.
);
    initial req_o = '0;
    task automatic send(input sez_pkg::sez_cmd_type c,
        input sez_pkg::sez_zone_type z, input logic [3:0] s,
        input logic lr, input logic [3:0] w, input logic ok);
        @(posedge clk_i);
        #1;
        req_o = '{1'b1, c, z, s, lr, w, ok};
        @(posedge clk_i);
        #1;
        req_o = ~req_o;
    endtask : send
endmodule : sez_host_model

// File: sez_zone_access_bench.sv
`timescale 1ns/1ps
module sez_zone_access_bench;
    localparam logic [511:0] IMG = {32'h11223344, 448'h0, 32'hC0FFEE01};
    logic                  clk_i;
    logic                  rst_b_i;
    logic                  sleep_i;
    logic                  p13;
    logic                  p15;
    sez_pkg::sez_req_type  req;
    sez_pkg::sez_resp_type resp;
    logic                  busy;
    logic                  l13;
    logic                  l15;
    logic                  kv;
    sez_pkg::sez_sram_type sram;
    int                    n_mismatch = 0;
    int                    check_count = 0;
    localparam logic [7:0]            OK  = sez_pkg::STAT_OK;
    localparam logic [7:0]            NO  = sez_pkg::STAT_REFUSED;
    localparam sez_pkg::sez_zone_type DAT = sez_pkg::ZONE_DATA;
    localparam sez_pkg::sez_zone_type OTP = sez_pkg::ZONE_OTP;
    sez_host_model sez_host_model_i (.clk_i(clk_i), .req_o(req));
    sez_zone_access #(.OTP_IMAGE(IMG)) sez_zone_access_i (.clk_i(clk_i),
        .rst_b_i(rst_b_i), .req_i(req), .sleep_i(sleep_i),
        .slot13_perm_i(p13), .slot15_perm_i(p15), .resp_o(resp),
        .busy_o(busy), .locked13_o(l13), .locked15_o(l15),
        .key_valid_o(kv), .sram_valid_o(sram));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic chk_bit(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit
    task automatic chk_word(input string n, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word
    task automatic op(input sez_pkg::sez_cmd_type c, input logic [3:0] s,
        input logic [7:0] st, input sez_pkg::sez_zone_type z = DAT,
        input logic ok = 1'b1);
        sez_host_model_i.send(c, z, s, 1'b0, 4'h0, ok);
        chk_bit("resp_valid", 1'b1, resp.valid);
        chk_word("status", {24'h0, st}, {24'h0, resp.status});
        chk_word("data", 32'h0, resp.data);
        if (st != sez_pkg::STAT_MISCOMPARE) begin
            chk_bit("granted", st == OK, resp.granted);
        end
    endtask : op
    task automatic t_otp;
        sez_host_model_i.send(sez_pkg::CMD_READ, OTP, 4'h0, 1'b0, 4'h0, 1);
        chk_word("otp_w0", IMG[511:480], resp.data);
        sez_host_model_i.send(sez_pkg::CMD_READ, OTP, 4'h0, 1'b0, 4'hF, 1);
        chk_word("otp_w15", IMG[31:0], resp.data);
        sez_host_model_i.send(sez_pkg::CMD_READ, OTP, 4'h0, 1'b1, 4'h9, 1);
        for (int i = 0; i < 8; i++) begin
            chk_word("burst", IMG[255-32*i -: 32], resp.data);
            chk_bit("last", i == 7, resp.last);
            if (i < 7) chk_bit("busy", 1'b1, busy);
            @(posedge clk_i);
            #1;
        end
        chk_bit("after_burst", 1'b0, resp.valid || busy);
        op(sez_pkg::CMD_WRITE, 4'h0, NO, OTP);
        op(sez_pkg::CMD_LOCK_SLOT, 4'h0, NO, OTP);
        op(sez_pkg::CMD_READ, 4'h0, NO, sez_pkg::ZONE_SRAM);
        $display("t_otp done");
    endtask : t_otp
    task automatic t_hash;
        op(sez_pkg::CMD_HASH_UPDATE, 4'hD, NO);
        op(sez_pkg::CMD_HASH_INIT, 4'hD, OK);
        op(sez_pkg::CMD_HASH_UPDATE, 4'hD, OK);
        op(sez_pkg::CMD_NONCE, 4'hD, OK);
        op(sez_pkg::CMD_HASH_UPDATE, 4'hD, OK);
        chk_bit("alt_secret", 1'b0, sram.alt_secret);
        op(sez_pkg::CMD_HASH_FINAL, 4'hD, OK);
        chk_bit("digest", 1'b1, sram.digest && !sram.hash_ctx);
        op(sez_pkg::CMD_KEY_DERIVATION, 4'hD, OK);
        chk_bit("alt_key", 1'b1, sram.alt_key && sram.alt_secret);
        $display("t_hash done");
    endtask : t_hash
    task automatic t_key14;
        chk_bit("key_reset", 1'b0, kv);
        op(sez_pkg::CMD_VERIFY_VALIDATE, 4'hE, sez_pkg::STAT_MISCOMPARE, DAT,
            1'b0);
        chk_bit("key_miss", 1'b0, kv);
        op(sez_pkg::CMD_VERIFY_VALIDATE, 4'hE, OK);
        chk_bit("key_set", 1'b1, kv);
        op(sez_pkg::CMD_WRITE, 4'hE, NO);
        op(sez_pkg::CMD_READ, 4'hE, OK);
        op(sez_pkg::CMD_VERIFY_STORED, 4'hE, OK);
        op(sez_pkg::CMD_VERIFY_INVALIDATE, 4'hE, OK);
        chk_bit("key_clear", 1'b0, kv);
        op(sez_pkg::CMD_READ, 4'hE, OK);
        op(sez_pkg::CMD_VERIFY_STORED, 4'hE, NO);
        op(sez_pkg::CMD_WRITE, 4'hE, OK);
        $display("t_key14 done");
    endtask : t_key14
    task automatic t_slot13;
        p13 = 1'b1;
        op(sez_pkg::CMD_WRITE, 4'hD, NO);
        chk_bit("perm13", 1'b1, l13);
        p13 = 1'b0;
        op(sez_pkg::CMD_WRITE, 4'hD, OK);
        op(sez_pkg::CMD_MAC, 4'hD, OK);
        op(sez_pkg::CMD_LOCK_SLOT, 4'hD, OK);
        chk_bit("locked13", 1'b1, l13);
        op(sez_pkg::CMD_WRITE, 4'hD, NO);
        op(sez_pkg::CMD_READ, 4'hD, OK);
        op(sez_pkg::CMD_READ, 4'h5, NO);
        $display("t_slot13 done");
    endtask : t_slot13
    task automatic t_slot15;
        p15 = 1'b1;
        op(sez_pkg::CMD_WRITE, 4'hF, NO);
        chk_bit("locked15", 1'b1, l15);
        op(sez_pkg::CMD_READ, 4'hF, OK);
        op(sez_pkg::CMD_DIGEST_GENERATE, 4'hF, OK);
        chk_bit("scratch", 1'b1, sram.scratch_hi && sram.scratch_lo);
        p15 = 1'b0;
        op(sez_pkg::CMD_WRITE, 4'hF, OK);
        op(sez_pkg::CMD_VERIFY_STORED, 4'hF, NO);
        op(sez_pkg::CMD_LOCK_SLOT, 4'hF, OK);
        op(sez_pkg::CMD_WRITE, 4'hF, NO);
        $display("t_slot15 done");
    endtask : t_slot15
    task automatic t_sleep;
        op(sez_pkg::CMD_HASH_INIT, 4'hD, OK);
        @(posedge clk_i);
        #1;
        sleep_i = 1'b1;
        @(posedge clk_i);
        #1;
        sleep_i = 1'b0;
        chk_word("sram", 32'h0, {26'h0, sram});
        op(sez_pkg::CMD_HASH_UPDATE, 4'hD, NO);
        $display("t_sleep done");
    endtask : t_sleep
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        rst_b_i = 1'b0;
        sleep_i = 1'b0;
        p13 = 1'b0;
        p15 = 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        t_otp();
        t_hash();
        t_key14();
        t_slot13();
        t_slot15();
        t_sleep();
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        wrap_up();
    end
endmodule : sez_zone_access_bench
